//--- design/tcp_link_if.sv
// pin-level link between the sensor end and the controller end
`timescale 1ns/1ps
interface tcp_link_if;
	logic turnsDevOut;
	logic turnsDevOe;
	logic turnsHostOut;
	logic turnsHostOe;
	logic pdHostOut;
	logic turnsPin;
	logic pdPin;

	// open-drain turn pin with pull-up
	assign turnsPin = !((turnsDevOe && !turnsDevOut)
		|| (turnsHostOe && !turnsHostOut));
	assign pdPin = pdHostOut;

	modport dev (
		input  turnsPin,
		input  pdPin,
		output turnsDevOut,
		output turnsDevOe
	);
	modport host (
		input  turnsPin,
		output turnsHostOut,
		output turnsHostOe,
		output pdHostOut
	);
endinterface

//--- design/tcp_pkg.sv
// constants, types and duty arithmetic for the turn-count pin link
// Functional notes
// RULE1 - PWM carrier at 2.5 kHz while counting
// RULE2 - duty held between 10 and 90 percent
// RULE3 - 50 percent at zero, 0.039 percent per turn
// RULE4 - turn pin low 125 us starts counting
// RULE5 - turn pin low 1.1 ms clears tally
// RULE6 - first falling edge 55 us after release
// RULE7 - power pin low 125 to 400 us
// RULE8 - pulses spaced 25 to 400 us, else timeout
// RULE9 - power pin low 1.1 ms means full sleep
// RULE10 - low-power mode wakes every 25 ms
// RULE11 - gain loop 4 us, then 1 s past 60 percent
// RULE12 - quarter-turn steps from two hall switches
package tcp_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_NS = 40;
	localparam int PWM_HZ = 2500;
	localparam int PCT = 100;
	localparam int PPM = 1_000_000;
	localparam int DUTY_MIN_PCT = 10;
	localparam int DUTY_MAX_PCT = 90;
	localparam int DUTY_ZERO_PCT = 50;
	localparam int STEP_PPM = 390;
	localparam int TALLY_W = 11;
	localparam int TALLY_MIN = -1024;
	localparam int TALLY_MAX = 1023;
	localparam int T_START_NS = 125_000;
	localparam int T_CLEAR_NS = 1_100_000;
	localparam int T_DELAY_NS = 55_000;
	localparam int T_PD_MIN_NS = 125_000;
	localparam int T_PD_MAX_NS = 400_000;
	localparam int T_GAP_MIN_NS = 25_000;
	localparam int T_GAP_MAX_NS = 400_000;
	localparam int T_SLEEP_NS = 1_100_000;
	localparam int T_NAP_NS = 25_000_000;
	localparam int T_AGC_FAST_NS = 4_000;
	localparam int T_AGC_SLOW_NS = 1_000_000_000;
	localparam int T_HSTART_NS = 150_000;
	localparam int T_HCLEAR_NS = 1_200_000;
	localparam int T_HLP_NS = 200_000;
	localparam int PD_PULSES = 1;
	localparam int PWM_SLACK_DIV = 4;

	function automatic int minCyc(input int ns);
		return (ns + CLK_NS - 1) / CLK_NS;
	endfunction

	function automatic int maxCyc(input int ns);
		return (ns < CLK_NS) ? 1 : ns / CLK_NS;
	endfunction

	localparam int PWM_CYC = CLK_HZ / PWM_HZ;
	localparam int START_CYC = minCyc(T_START_NS);
	localparam int CLEAR_CYC = minCyc(T_CLEAR_NS);
	localparam int DELAY_CYC = maxCyc(T_DELAY_NS);
	localparam int PD_MIN_CYC = minCyc(T_PD_MIN_NS);
	localparam int PD_MAX_CYC = maxCyc(T_PD_MAX_NS);
	localparam int GAP_MIN_CYC = minCyc(T_GAP_MIN_NS);
	localparam int GAP_MAX_CYC = maxCyc(T_GAP_MAX_NS);
	localparam int SLEEP_CYC = minCyc(T_SLEEP_NS);
	localparam int NAP_CYC = maxCyc(T_NAP_NS);
	localparam int AGC_FAST_CYC = maxCyc(T_AGC_FAST_NS);
	localparam int AGC_SLOW_CYC = maxCyc(T_AGC_SLOW_NS);
	localparam int HSTART_CYC = minCyc(T_HSTART_NS);
	localparam int HCLEAR_CYC = minCyc(T_HCLEAR_NS);
	localparam int HLP_CYC = minCyc(T_HLP_NS);

	typedef enum logic [1:0] {TS_OFF, TS_HOLD, TS_DELAY, TS_RUN} tcp_turn_e;
	typedef enum logic [1:0] {PM_ACTIVE, PM_LOWPWR, PM_SLEEP} tcp_power_e;
	typedef enum logic [2:0] {
		HS_IDLE, HS_WAITHI, HS_TURNLOW, HS_PDLOW, HS_ASLEEP
	} tcp_host_e;

	// high time in cycles for a tally; longint keeps the product exact
	function automatic int tallyToHigh(input int tally, input int period);
		longint h;
		longint lo;
		longint hi;
		h = longint'(period) * DUTY_ZERO_PCT / PCT
			+ longint'(tally) * period * STEP_PPM / PPM;
		lo = longint'(period) * DUTY_MIN_PCT / PCT;
		hi = longint'(period) * DUTY_MAX_PCT / PCT;
		if (h < lo) h = lo;
		if (h > hi) h = hi;
		return int'(h);
	endfunction

	// inverse, rounded to nearest turn symmetric about zero
	function automatic int highToTally(input int high, input int period);
		longint num;
		longint den;
		num = (longint'(high) - longint'(period) * DUTY_ZERO_PCT / PCT) * PPM;
		den = longint'(period) * STEP_PPM;
		if (num < 0) return int'((num - den / 2) / den);
		return int'((num + den / 2) / den);
	endfunction
endpackage

//--- design/tcp_turns_dev.sv
// sensor end: tally, PWM on the turn pin, power-pin mode control, AGC pacing
`timescale 1ns/1ps
module tcp_turns_dev #(
	parameter int unsigned PWM_CYC      = tcp_pkg::PWM_CYC,
	parameter int unsigned CLEAR_CYC    = tcp_pkg::CLEAR_CYC,
	parameter int unsigned PD_MAX_CYC   = tcp_pkg::PD_MAX_CYC,
	parameter int unsigned GAP_MAX_CYC  = tcp_pkg::GAP_MAX_CYC,
	parameter int unsigned SLEEP_CYC    = tcp_pkg::SLEEP_CYC,
	parameter int unsigned NAP_CYC      = tcp_pkg::NAP_CYC,
	parameter int unsigned AGC_SLOW_CYC = tcp_pkg::AGC_SLOW_CYC,
	parameter int unsigned PD_PULSES    = tcp_pkg::PD_PULSES
) (
	// clock and reset
	input  wire logic                           clk_sys,
	input  wire logic                           rst_n,
	// pins
	tcp_link_if.dev                             link,
	// sensor front end
	input  wire logic                           hallX,
	input  wire logic                           hallY,
	input  wire logic                           ampHigh,
	// status
	output logic signed [tcp_pkg::TALLY_W-1:0] rotationTally,
	output logic                                countingOn,
	output logic                                dutyCycledMode,
	output logic                                sleepMode,
	output logic                                senseWake,
	output logic                                agcUpdate
);
	localparam int unsigned START_CYC    = tcp_pkg::START_CYC;
	localparam int unsigned DELAY_CYC    = tcp_pkg::DELAY_CYC;
	localparam int unsigned PD_MIN_CYC   = tcp_pkg::PD_MIN_CYC;
	localparam int unsigned GAP_MIN_CYC  = tcp_pkg::GAP_MIN_CYC;
	localparam int unsigned AGC_FAST_CYC = tcp_pkg::AGC_FAST_CYC;
	localparam int W = tcp_pkg::TALLY_W;

	function automatic logic [31:0] inc(input logic [31:0] v);
		return (v == 32'hFFFF_FFFF) ? v : v + 32'h1;
	endfunction

	// gray position of the two switches, 00-01-11-10 counts forward
	function automatic logic [1:0] qPos(input logic [1:0] xy);
		return {xy[1], xy[1] ^ xy[0]};
	endfunction

	// synchronisers
	logic [1:0] sTurn;
	logic [1:0] sPd;
	logic [1:0] sX;
	logic [1:0] sY;
	logic [1:0] sAmp;
	logic [1:0] oeHist;

	// turn-pin group
	tcp_pkg::tcp_turn_e tState;
	tcp_pkg::tcp_turn_e next_tState;
	logic [31:0]        lowCnt;
	logic [31:0]        next_lowCnt;
	logic [31:0]        phase;
	logic [31:0]        next_phase;
	logic [31:0]        highCyc;
	logic [31:0]        next_highCyc;
	logic               drv;
	logic               next_drv;
	logic               next_countingOn;
	logic signed [W-1:0] next_tally;
	logic [1:0]         quarter;
	logic [1:0]         next_quarter;
	logic [1:0]         prevXY;
	logic [1:0]         next_prevXY;
	logic [1:0]         step;
	logic [1:0]         curXY;
	logic               pinLow;
	logic               extLow;
	logic               sampleOk;

	// power-pin group
	tcp_pkg::tcp_power_e pState;
	tcp_pkg::tcp_power_e next_pState;
	logic [31:0]         pdLow;
	logic [31:0]         next_pdLow;
	logic [31:0]         gapCnt;
	logic [31:0]         next_gapCnt;
	logic [7:0]          pulses;
	logic [7:0]          next_pulses;
	logic                seqOpen;
	logic                next_seqOpen;
	logic                pdPrev;
	logic                pdIsLow;
	logic                pdRise;
	logic                pdFall;

	// pacing group
	logic [31:0] napCnt;
	logic [31:0] next_napCnt;
	logic        next_senseWake;
	logic [31:0] agcCnt;
	logic [31:0] next_agcCnt;
	logic [31:0] agcLimit;
	logic        agcSlow;
	logic        next_agcSlow;
	logic        next_agcUpdate;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sTurn <= 2'h3;
			sPd <= 2'h3;
			sX <= 2'h0;
			sY <= 2'h0;
			sAmp <= 2'h0;
			oeHist <= 2'h0;
			pdPrev <= 1'b1;
		end else begin
			sTurn <= {sTurn[0], link.turnsPin};
			sPd <= {sPd[0], link.pdPin};
			sX <= {sX[0], hallX};
			sY <= {sY[0], hallY};
			sAmp <= {sAmp[0], ampHigh};
			oeHist <= {oeHist[0], drv};
			pdPrev <= sPd[1];
		end
	end

	assign curXY = {sX[1], sY[1]};
	assign pinLow = !sTurn[1];
	// our own low phase echoes through the synchroniser for two cycles
	assign extLow = pinLow && !drv && (oeHist == 2'h0);
	// in low power the switches are only looked at on a wake, so
	// faster rotation than the nap allows loses quarter steps
	assign sampleOk = (pState != tcp_pkg::PM_SLEEP)
		&& ((pState != tcp_pkg::PM_LOWPWR) || senseWake); // see RULE10
	assign step = qPos(curXY) - qPos(prevXY);

	always_comb begin
		next_tState = tState;
		next_lowCnt = lowCnt;
		next_phase = phase;
		next_highCyc = highCyc;
		next_drv = drv;
		next_countingOn = countingOn;
		next_tally = rotationTally;
		next_quarter = quarter;
		next_prevXY = prevXY;
		if (sampleOk) begin
			next_prevXY = curXY;
			if (countingOn && step == 2'h1) begin // see RULE12
				next_quarter = quarter + 2'h1;
				if (quarter == 2'h3 && rotationTally != W'(tcp_pkg::TALLY_MAX))
					next_tally = rotationTally + W'(1); // see RULE3
			end else if (countingOn && step == 2'h3) begin // see RULE12
				next_quarter = quarter - 2'h1;
				if (quarter == 2'h0 && rotationTally != W'(tcp_pkg::TALLY_MIN))
					next_tally = rotationTally - W'(1); // see RULE3
			end
		end
		case (tState)
			tcp_pkg::TS_HOLD: begin
				if (pState == tcp_pkg::PM_SLEEP) begin
					next_tState = tcp_pkg::TS_OFF;
					next_countingOn = 1'b0;
				end else if (pinLow) begin
					next_lowCnt = inc(lowCnt);
				end else begin
					if (lowCnt >= CLEAR_CYC) begin // see RULE5
						next_tally = '0;
						next_quarter = 2'h0;
					end
					next_phase = 32'h0;
					if (lowCnt >= START_CYC) begin // see RULE4
						next_tState = tcp_pkg::TS_DELAY;
						next_countingOn = 1'b1;
					end else if (countingOn) begin
						next_tState = tcp_pkg::TS_RUN;
					end else begin
						next_tState = tcp_pkg::TS_OFF;
					end
				end
			end
			default: begin
				if (pState == tcp_pkg::PM_SLEEP) begin
					next_tState = tcp_pkg::TS_OFF;
					next_drv = 1'b0;
					next_countingOn = 1'b0;
				end else if (extLow) begin
					next_tState = tcp_pkg::TS_HOLD;
					next_lowCnt = 32'h1;
					next_drv = 1'b0;
				end else if (tState == tcp_pkg::TS_DELAY) begin
					next_phase = phase + 32'h1;
					if (phase >= DELAY_CYC - 1) begin // see RULE6
						next_tState = tcp_pkg::TS_RUN;
						next_phase = 32'h0;
						next_highCyc = 32'(tcp_pkg::tallyToHigh(
							int'(rotationTally), int'(PWM_CYC))); // see RULE2
						next_drv = 1'b1;
					end
				end else if (tState == tcp_pkg::TS_RUN) begin
					if (phase >= PWM_CYC - 1) begin // see RULE1
						next_phase = 32'h0;
						// duty only changes at a period boundary
						next_highCyc = 32'(tcp_pkg::tallyToHigh(
							int'(rotationTally), int'(PWM_CYC))); // see RULE3
					end else begin
						next_phase = phase + 32'h1;
					end
					next_drv = next_phase < PWM_CYC - next_highCyc; // see RULE2
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tState <= tcp_pkg::TS_OFF;
			lowCnt <= 32'h0;
			phase <= 32'h0;
			highCyc <= 32'h0;
			drv <= 1'b0;
			countingOn <= 1'b0;
			rotationTally <= '0;
			quarter <= 2'h0;
			prevXY <= 2'h0;
		end else begin
			tState <= next_tState;
			lowCnt <= next_lowCnt;
			phase <= next_phase;
			highCyc <= next_highCyc;
			drv <= next_drv;
			countingOn <= next_countingOn;
			rotationTally <= next_tally;
			quarter <= next_quarter;
			prevXY <= next_prevXY;
		end
	end

	assign link.turnsDevOe = drv;
	assign link.turnsDevOut = 1'b0;

	assign pdIsLow = !sPd[1];
	assign pdRise = sPd[1] && !pdPrev;
	assign pdFall = !sPd[1] && pdPrev;

	always_comb begin
		next_pState = pState;
		next_pdLow = pdIsLow ? inc(pdLow) : 32'h0;
		next_gapCnt = (!pdIsLow && seqOpen) ? inc(gapCnt) : 32'h0;
		next_pulses = pulses;
		next_seqOpen = seqOpen;
		case (pState)
			tcp_pkg::PM_SLEEP: begin
				next_seqOpen = 1'b0;
				next_pulses = 8'h0;
				if (pdRise)
					next_pState = tcp_pkg::PM_ACTIVE;
			end
			default: begin
				if (pdIsLow && pdLow >= SLEEP_CYC - 1) begin // see RULE9
					next_pState = tcp_pkg::PM_SLEEP;
					next_seqOpen = 1'b0;
					next_pulses = 8'h0;
				end else if (pdFall && seqOpen && gapCnt < GAP_MIN_CYC) begin
					next_seqOpen = 1'b0; // see RULE8
					next_pulses = 8'h0;
				end else if (pdRise) begin
					if (pdLow >= PD_MIN_CYC && pdLow <= PD_MAX_CYC) begin
						next_pulses = pulses + 8'h1; // see RULE7
						next_seqOpen = 1'b1;
					end else begin
						next_seqOpen = 1'b0;
						next_pulses = 8'h0;
					end
				end else if (seqOpen && gapCnt >= GAP_MAX_CYC - 1) begin
					// gap ran out: the sequence closes and takes effect
					if (32'(pulses) >= PD_PULSES) // see RULE8
						next_pState = (pState == tcp_pkg::PM_ACTIVE)
							? tcp_pkg::PM_LOWPWR : tcp_pkg::PM_ACTIVE;
					next_seqOpen = 1'b0;
					next_pulses = 8'h0;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pState <= tcp_pkg::PM_ACTIVE;
			pdLow <= 32'h0;
			gapCnt <= 32'h0;
			pulses <= 8'h0;
			seqOpen <= 1'b0;
		end else begin
			pState <= next_pState;
			pdLow <= next_pdLow;
			gapCnt <= next_gapCnt;
			pulses <= next_pulses;
			seqOpen <= next_seqOpen;
		end
	end

	assign dutyCycledMode = (pState == tcp_pkg::PM_LOWPWR);
	assign sleepMode = (pState == tcp_pkg::PM_SLEEP);

	assign agcLimit = agcSlow ? AGC_SLOW_CYC : AGC_FAST_CYC; // see RULE11

	always_comb begin
		next_napCnt = 32'h0;
		next_senseWake = 1'b0;
		if (pState == tcp_pkg::PM_LOWPWR) begin
			if (napCnt >= NAP_CYC - 1) begin // see RULE10
				next_senseWake = 1'b1;
			end else begin
				next_napCnt = napCnt + 32'h1;
			end
		end
		next_agcSlow = agcSlow || sAmp[1]; // see RULE11
		next_agcCnt = 32'h0;
		next_agcUpdate = 1'b0;
		if (pState != tcp_pkg::PM_SLEEP) begin
			if (agcCnt >= agcLimit - 1) begin
				next_agcUpdate = 1'b1;
			end else begin
				next_agcCnt = agcCnt + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			napCnt <= 32'h0;
			senseWake <= 1'b0;
			agcCnt <= 32'h0;
			agcSlow <= 1'b0;
			agcUpdate <= 1'b0;
		end else begin
			napCnt <= next_napCnt;
			senseWake <= next_senseWake;
			agcCnt <= next_agcCnt;
			agcSlow <= next_agcSlow;
			agcUpdate <= next_agcUpdate;
		end
	end
endmodule // tcp_turns_dev

//--- design/tcp_turns_host.sv
// controller end: drives start/clear and power commands, decodes the PWM
`timescale 1ns/1ps
module tcp_turns_host #(
	parameter int unsigned PWM_CYC    = tcp_pkg::PWM_CYC,
	parameter int unsigned HCLEAR_CYC = tcp_pkg::HCLEAR_CYC,
	parameter int unsigned HLP_CYC    = tcp_pkg::HLP_CYC,
	parameter int unsigned HSLEEP_CYC = tcp_pkg::HCLEAR_CYC
) (
	// clock and reset
	input  wire logic                           clk_sys,
	input  wire logic                           rst_n,
	// pins
	tcp_link_if.host                            link,
	// commands
	input  wire logic                           cmdStart,
	input  wire logic                           cmdClear,
	input  wire logic                           cmdLowPower,
	input  wire logic                           cmdSleep,
	input  wire logic                           cmdWake,
	// results
	output logic                                busy,
	output logic                                tallyValid,
	output logic signed [tcp_pkg::TALLY_W-1:0] tally
);
	localparam int unsigned HSTART_CYC = tcp_pkg::HSTART_CYC;
	localparam int W = tcp_pkg::TALLY_W;

	tcp_pkg::tcp_host_e hState;
	tcp_pkg::tcp_host_e next_hState;
	logic [31:0]         cnt;
	logic [31:0]         next_cnt;
	logic [31:0]         holdLen;
	logic [31:0]         next_holdLen;
	logic [31:0]         hiCnt;
	logic [31:0]         phCnt;
	logic [31:0]         next_phCnt;
	logic [31:0]         lowLen;
	logic [31:0]         next_lowLen;
	logic                oe;
	logic                next_oe;
	logic                pdOut;
	logic                next_pdOut;
	logic                armed;
	logic                next_armed;
	logic                next_valid;
	logic signed [W-1:0] next_tally;
	logic [1:0]          sPin;
	logic                pinPrev;
	logic                pinRise;
	logic                pinFall;

	assign pinRise = sPin[1] && !pinPrev;
	assign pinFall = !sPin[1] && pinPrev;

	always_comb begin
		next_hState = hState;
		next_cnt = cnt + 32'h1;
		next_holdLen = holdLen;
		next_oe = oe;
		next_pdOut = pdOut;
		case (hState)
			tcp_pkg::HS_IDLE: begin
				if (cmdStart || cmdClear) begin
					next_hState = tcp_pkg::HS_WAITHI;
					next_holdLen = cmdClear ? HCLEAR_CYC : HSTART_CYC; // see RULE5
				end else if (cmdLowPower) begin
					next_hState = tcp_pkg::HS_PDLOW;
					next_holdLen = HLP_CYC; // see RULE7
					next_cnt = 32'h0;
					next_pdOut = 1'b0;
				end else if (cmdSleep) begin
					next_hState = tcp_pkg::HS_PDLOW;
					next_holdLen = HSLEEP_CYC; // see RULE9
					next_cnt = 32'h0;
					next_pdOut = 1'b0;
				end
			end
			tcp_pkg::HS_WAITHI: begin
				// start just after the sensor lets go, so its own low
				// phase cannot hide the first part of our hold
				if (pinRise || hiCnt >= PWM_CYC) begin
					next_hState = tcp_pkg::HS_TURNLOW;
					next_cnt = 32'h0;
					next_oe = 1'b1;
				end
			end
			tcp_pkg::HS_TURNLOW: begin
				if (cnt >= holdLen - 1) begin // see RULE4
					next_hState = tcp_pkg::HS_IDLE;
					next_oe = 1'b0;
				end
			end
			tcp_pkg::HS_PDLOW: begin
				if (cnt >= holdLen - 1) begin
					next_hState = (holdLen == HLP_CYC)
						? tcp_pkg::HS_IDLE : tcp_pkg::HS_ASLEEP;
					next_pdOut = (holdLen == HLP_CYC);
				end
			end
			default: begin
				if (cmdWake) begin
					next_hState = tcp_pkg::HS_IDLE;
					next_pdOut = 1'b1;
				end
			end
		endcase
	end

	always_comb begin
		next_phCnt = phCnt + 32'h1;
		next_lowLen = lowLen;
		next_armed = armed && (hState == tcp_pkg::HS_IDLE);
		next_valid = 1'b0;
		next_tally = tally;
		if (pinRise)
			next_lowLen = phCnt;
		if (pinFall) begin
			next_phCnt = 32'h0;
			next_armed = (hState == tcp_pkg::HS_IDLE);
			if (armed && phCnt <= PWM_CYC + PWM_CYC / tcp_pkg::PWM_SLACK_DIV)
			begin
				next_valid = 1'b1;
				next_tally = W'(tcp_pkg::highToTally(
					int'(phCnt - lowLen), int'(PWM_CYC))); // see RULE3
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sPin <= 2'h3;
			pinPrev <= 1'b1;
			hiCnt <= 32'h0;
			hState <= tcp_pkg::HS_IDLE;
			cnt <= 32'h0;
			holdLen <= 32'h0;
			oe <= 1'b0;
			pdOut <= 1'b1;
			phCnt <= 32'h0;
			lowLen <= 32'h0;
			armed <= 1'b0;
			tallyValid <= 1'b0;
			tally <= '0;
		end else begin
			sPin <= {sPin[0], link.turnsPin};
			pinPrev <= sPin[1];
			hiCnt <= sPin[1] ? hiCnt + 32'h1 : 32'h0;
			hState <= next_hState;
			cnt <= next_cnt;
			holdLen <= next_holdLen;
			oe <= next_oe;
			pdOut <= next_pdOut;
			phCnt <= next_phCnt;
			lowLen <= next_lowLen;
			armed <= next_armed;
			tallyValid <= next_valid;
			tally <= next_tally;
		end
	end

	assign busy = (hState != tcp_pkg::HS_IDLE);
	assign link.turnsHostOe = oe;
	assign link.turnsHostOut = 1'b0;
	assign link.pdHostOut = pdOut;
endmodule // tcp_turns_host

//--- tb/tcp_link_checker.sv
// assertions on the turn-pin and power-pin wires of the link
`timescale 1ns/1ps
module tcp_link_checker #(
	parameter int PWM_CYC    = 200,
	parameter int PD_MAX_CYC = 5000,
	parameter int SLEEP_CYC  = 8000
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// link wires
	input wire logic turnsDevOut,
	input wire logic turnsDevOe,
	input wire logic turnsHostOut,
	input wire logic turnsHostOe,
	input wire logic pdHostOut,
	input wire logic turnsPin,
	input wire logic pdPin
);
	localparam int DLY = tcp_pkg::DELAY_CYC;
	int   perCnt;
	int   dlyCnt;
	int   hLowCnt;
	int   pdLowCnt;
	logic armed;
	logic hostSeen;
	logic waitFirst;

	// host activity spoils the next period, so those are skipped
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			perCnt <= 0;
			dlyCnt <= 0;
			hLowCnt <= 0;
			pdLowCnt <= 0;
			armed <= 1'h0;
			hostSeen <= 1'h0;
			waitFirst <= 1'h0;
		end else begin
			perCnt <= $rose(turnsDevOe) ? 0 : perCnt + 1;
			dlyCnt <= $fell(turnsHostOe) ? 0 : dlyCnt + 1;
			hLowCnt <= turnsHostOe ? hLowCnt + 1 : 0;
			pdLowCnt <= pdHostOut ? 0 : pdLowCnt + 1;
			armed <= armed | $rose(turnsDevOe);
			hostSeen <= $rose(turnsDevOe) ? 1'h0
				: hostSeen | (!turnsPin && !turnsDevOe) | !pdPin;
			waitFirst <= $fell(turnsHostOe) ? 1'h1
				: ($rose(turnsDevOe) ? 1'h0 : waitFirst);
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_dev_opendrain: assert property (turnsDevOe |->
		!turnsDevOut && !turnsPin)
		else $error("turn pin not low while device drives");
	a_host_opendrain: assert property (turnsHostOe |->
		!turnsHostOut && !turnsPin)
		else $error("turn pin not low while host drives");
	a_reset_idle: assert property ($rose(rst_n) |->
		!turnsDevOe && !turnsHostOe && pdHostOut)
		else $error("pins not idle after reset");
	a_pwm_period: assert property (armed && !hostSeen && $rose(turnsDevOe)
		|-> perCnt == PWM_CYC - 1)
		else $error("carrier period wrong");
	a_duty_range: assert property (armed && !hostSeen && $fell(turnsDevOe)
		|-> perCnt >= PWM_CYC / 10 - 1 && perCnt <= PWM_CYC * 9 / 10 - 1)
		else $error("duty outside range");
	a_first_fall: assert property (waitFirst && $rose(turnsDevOe)
		|-> dlyCnt >= DLY - 10 && dlyCnt <= DLY + 10)
		else $error("first falling edge late or early");
	a_start_hold: assert property ($fell(turnsHostOe)
		|-> hLowCnt >= tcp_pkg::START_CYC - 1)
		else $error("turn pin low too short");
	a_pd_pulse: assert property ($rose(pdHostOut) |->
		(pdLowCnt >= tcp_pkg::PD_MIN_CYC - 1 && pdLowCnt <= PD_MAX_CYC)
		|| pdLowCnt >= SLEEP_CYC)
		else $error("power pin pulse length wrong");

	c_period: cover property (armed && !hostSeen && $rose(turnsDevOe));
	c_first: cover property (waitFirst && $rose(turnsDevOe));
	c_sleep: cover property ($rose(pdHostOut) && pdLowCnt >= SLEEP_CYC);
endmodule // tcp_link_checker

//--- tb/tcp_turns_tb_top.sv
// bench joining sensor end and controller end over the link
`timescale 1ns/1ps
module tcp_turns_tb_top;
	localparam int PW = 200;
	localparam int SP = PW * tcp_pkg::STEP_PPM;
	// shortened timings handed to the sensor end, the controller end and the checker
	localparam int CLR = 4000, PDM = 5000, GMX = 2000, SLP = 8000;
	localparam int NAP = 500, AGS = 300, HCL = 4500, HLP = 4000;
	localparam int HSL = 9000;
	logic                             clk_sys;
	logic                             rst_n;
	logic [4:0]                       cmd;
	logic [1:0]                       hall;
	logic                             ampHigh;
	logic                             busy;
	logic                             tallyValid;
	logic                             countingOn;
	logic                             dutyCycledMode;
	logic                             sleepMode;
	logic                             senseWake;
	logic                             agcUpdate;
	logic signed [tcp_pkg::TALLY_W-1:0] rotationTally;
	logic signed [tcp_pkg::TALLY_W-1:0] tally;
	int                               errCount;
	int                               checked;
	int                               cyc;
	int                               q;
	int                               expT;

	tcp_link_if link ();
	tcp_turns_dev #(.PWM_CYC(PW), .CLEAR_CYC(CLR), .PD_MAX_CYC(PDM),
		.GAP_MAX_CYC(GMX), .SLEEP_CYC(SLP), .NAP_CYC(NAP),
		.AGC_SLOW_CYC(AGS)) i_tcp_turns_dev (
		.clk_sys(clk_sys), .rst_n(rst_n), .link(link.dev),
		.hallX(hall[1]), .hallY(hall[0]), .ampHigh(ampHigh),
		.rotationTally(rotationTally), .countingOn(countingOn),
		.dutyCycledMode(dutyCycledMode), .sleepMode(sleepMode),
		.senseWake(senseWake), .agcUpdate(agcUpdate));
	tcp_turns_host #(.PWM_CYC(PW), .HCLEAR_CYC(HCL), .HLP_CYC(HLP),
		.HSLEEP_CYC(HSL)) i_tcp_turns_host (
		.clk_sys(clk_sys), .rst_n(rst_n), .link(link.host),
		.cmdStart(cmd[0]), .cmdClear(cmd[1]), .cmdLowPower(cmd[2]),
		.cmdSleep(cmd[3]), .cmdWake(cmd[4]), .busy(busy),
		.tallyValid(tallyValid), .tally(tally));
	tcp_link_checker #(.PWM_CYC(PW), .PD_MAX_CYC(PDM), .SLEEP_CYC(SLP))
	i_tcp_link_checker (.clk_sys(clk_sys), .rst_n(rst_n),
		.turnsDevOut(link.turnsDevOut), .turnsDevOe(link.turnsDevOe),
		.turnsHostOut(link.turnsHostOut), .turnsHostOe(link.turnsHostOe),
		.pdHostOut(link.pdHostOut), .turnsPin(link.turnsPin),
		.pdPin(link.pdPin));

	initial begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic completeRun();
		$display("checks %0d mismatches %0d", checked, errCount);
		if (errCount == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// run is far shorter than this; reaching it means a hang
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			errCount++;
			completeRun();
		end
	end

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errCount++;
			$display("[ERR] %s expected %0d seen %0d", nm, $signed(exp),
				$signed(seen));
		end
	endtask

	task automatic issue(int i, int lim);
		@(posedge clk_sys);
		cmd[i] <= 1'h1;
		@(posedge clk_sys);
		cmd <= 5'h00;
		repeat (2) @(negedge clk_sys);
		for (int n = 0; n < lim && busy !== 1'h0; n++) @(negedge clk_sys);
		repeat (4) @(negedge clk_sys);
	endtask

	function automatic logic pick(bit wake);
		return wake ? senseWake : agcUpdate;
	endfunction

	task automatic gap(bit wake, int exp);
		int n;
		for (n = 0; n < 2000 && pick(wake) !== 1'h1; n++) @(negedge clk_sys);
		for (n = 1; n < 2000; n++) begin
			@(negedge clk_sys);
			if (pick(wake) === 1'h1) break;
		end
		chk(wake ? "wakeGap" : "agcGap", n, exp);
	endtask

	// gray order 00-01-11-10 is forward; q starts and ends at 0
	task automatic spin(int turns);
		int s;
		for (s = 0; s < 4 * (turns < 0 ? -turns : turns); s++) begin
			q = turns > 0 ? (q + 1) % 4 : (q + 3) % 4;
			repeat (6) @(posedge clk_sys);
			hall <= {q[1], q[1] ^ q[0]};
		end
		expT = expT + turns;
		repeat (6) @(negedge clk_sys);
	endtask

	task automatic tallyChk();
		int h;
		int d;
		int n;
		h = PW / 2 + expT * SP / 1000000;
		d = (h - PW / 2) * 1000000;
		d = d < 0 ? (d - SP / 2) / SP : (d + SP / 2) / SP;
		chk("rotationTally", rotationTally, expT);
		// a fresh start needs the delay plus two falls before a result
		repeat (tcp_pkg::DELAY_CYC + PW) @(negedge clk_sys);
		for (n = 0; n < 2 * PW && tallyValid !== 1'h1; n++) @(negedge clk_sys);
		chk("tallyValid", tallyValid, 1);
		@(negedge clk_sys);
		chk("hostTally", tally, d);
		for (n = 0; n < 2 * PW && link.turnsPin !== 1'h0; n++) @(negedge clk_sys);
		for (n = 0; n < 2 * PW && link.turnsPin !== 1'h1; n++) @(negedge clk_sys);
		for (n = 0; n < 2 * PW && link.turnsPin === 1'h1; n++) @(negedge clk_sys);
		chk("highTime", n, h);
	endtask

	task automatic startRun();
		issue(0, 6000);
		chk("countingOn", countingOn, 1);
		chk("rotationTally", rotationTally, expT);
	endtask

	task automatic sleepRun();
		logic [31:0] act;
		issue(3, 0);
		repeat (HSL + 100) @(negedge clk_sys);
		chk("sleepMode", sleepMode, 1);
		chk("dutyCycledMode", dutyCycledMode, 0);
		act = 0;
		repeat (400) begin
			@(negedge clk_sys);
			act += !link.turnsPin + agcUpdate;
		end
		chk("sleepActivity", act, 0);
		issue(4, 100);
		chk("sleepMode", sleepMode, 0);
		chk("countingOn", countingOn, 0);
		chk("rotationTally", rotationTally, expT);
	endtask

	task automatic clearRun();
		issue(1, 8000);
		expT = 0;
		chk("rotationTally", rotationTally, 0);
		chk("countingOn", countingOn, 1);
		tallyChk();
	endtask

	task automatic lowRun();
		int n;
		issue(2, 6000);
		for (n = 0; n < 2100 && dutyCycledMode !== 1'h1; n++)
			@(negedge clk_sys);
		chk("dutyCycledMode", dutyCycledMode, 1);
		gap(1, NAP);
		issue(2, 6000);
		repeat (2100) @(negedge clk_sys);
		chk("dutyCycledMode", dutyCycledMode, 0);
	endtask

	initial begin
		rst_n = 1'h0;
		cmd = 5'h00;
		hall = 2'h0;
		ampHigh = 1'h0;
		q = 0;
		expT = 0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'h1;
		gap(0, 100);
		startRun();
		spin(64);
		tallyChk();
		spin(-128);
		tallyChk();
		sleepRun();
		startRun();
		clearRun();
		lowRun();
		@(posedge clk_sys);
		ampHigh <= 1'h1;
		repeat (400) @(negedge clk_sys);
		gap(0, AGS);
		completeRun();
	end
endmodule // tcp_turns_tb_top
